// file: verilog/awr_defines.svh
// offsets, reset values and sizes of the address and window registers
`ifndef AWR_DEFINES_SVH
`define AWR_DEFINES_SVH
`define AWR_OFS_PTR_TOP 7'h74
`define AWR_OFS_PTR_HIGH 7'h75
`define AWR_OFS_PTR_MID 7'h76
`define AWR_OFS_PTR_LOW 7'h77
`define AWR_OFS_WINDOW 7'h78
`define AWR_PTR_RESET 12'h0000
`define AWR_PTR_MAX 12'h0FFF
`define AWR_PTR_ONE 12'h0001
`define AWR_TOP_NIBBLE 4'h0
`define AWR_NIBBLE_ZERO 4'h0
`define AWR_STACK_DEPTH 8
`define AWR_SP_RESET 3'h0
`define AWR_SP_ONE 3'h1
`endif

// file: verilog/awr_pkg.sv
// types shared by the address and window register block
package awr_pkg;
   // operations decoded by the instruction sequencer
   typedef enum logic [3:0] {
      AWR_OP_NONE = 4'h0,
      AWR_OP_INC = 4'h1,
      AWR_OP_PUSH = 4'h2,
      AWR_OP_POP = 4'h3,
      AWR_OP_TREAD = 4'h4,
      AWR_OP_BR = 4'h5,
      AWR_OP_CALL = 4'h6,
      AWR_OP_FREAD = 4'h7,
      AWR_OP_FWRITE = 4'h8
   } awr_op_type;
   // system register access from the sequencer
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [3:0] wdata;
   } awr_sys_req_type;
   // table read sequence
   typedef enum logic {
      AWR_IDLE = 1'b0,
      AWR_FETCH = 1'b1
   } awr_state_type;
endpackage

// file: verilog/awr_stack.sv
// address stack with stack pointer used by pointer push and pop
`timescale 1ns/1ns
`include "awr_defines.svh"
module awr_stack
   import awr_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [11:0] wdata_i,
   output logic [11:0] rdata_o,
   output logic [2:0] sp_o
);
   logic [11:0] entry [`AWR_STACK_DEPTH]; // stack storage
   logic [11:0] next_entry [`AWR_STACK_DEPTH];
   logic [2:0] sp; // stack pointer
   logic [2:0] next_sp;
   logic [2:0] push_sp; // pointer after decrement

   // next stack pointer and entries
   always_comb begin
      push_sp = sp - `AWR_SP_ONE;
      next_sp = sp;
      next_entry = entry;
      if (push_i) begin
         next_sp = push_sp;
         next_entry[push_sp] = wdata_i;
      end else if (pop_i) begin
         next_sp = sp + `AWR_SP_ONE;
      end
   end

   // stack pointer register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sp <= `AWR_SP_RESET;
      end else if (en_i) begin
         sp <= next_sp;
      end
   end

   // entries keep contents across resets
   always_ff @(posedge clk_i) begin
      if (en_i) begin
         entry <= next_entry;
      end
   end

   // pop reads the entry at the current pointer
   assign rdata_o = entry[sp];
   assign sp_o = sp;
endmodule

// file: verilog/awr_core.sv
// program-memory pointer and window register of the cpu system registers
// Contract
// - pointer in four nibbles, top reads zero
// - pointer clears on all three resets
// - table read fetches word at pointer
// - push decrements stack pointer, then stores
// - pop loads pointer, then increments stack pointer
// - indirect branch jumps to pointer
// - indirect call enters subroutine at pointer
// - increment wraps 0FFF to 0000
// - pointer written and read via data buffer
// - one 4-bit window register in system space
// - file read copies file nibble to window
// - file write copies window to file
// - no index modification of these addresses
`timescale 1ns/1ns
`include "awr_defines.svh"
module awr_core
   import awr_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic clock_stop_i,
   input wire logic ce_reset_i,
   input wire awr_op_type op_i,
   input wire logic [6:0] rf_addr_i,
   input wire logic [3:0] rf_rdata_i,
   input wire awr_sys_req_type sys_i,
   input wire logic [15:0] rom_data_i,
   input wire logic dbf_ptr_load_i,
   input wire logic [11:0] dbf_ptr_data_i,
   output logic [3:0] sys_rdata_o,
   output logic [11:0] program_pointer_o,
   output logic [3:0] window_o,
   output logic rf_wr_o,
   output logic [6:0] rf_addr_o,
   output logic [3:0] rf_wdata_o,
   output logic rom_rd_o,
   output logic [11:0] rom_addr_o,
   output logic dbf_load_o,
   output logic [15:0] dbf_data_o,
   output logic pc_load_o,
   output logic call_o,
   output logic [11:0] pc_target_o,
   output logic [2:0] sp_o
);
   // read decode for the system register nibbles
   function automatic logic [3:0] sys_read(input logic [6:0] addr, input logic [11:0] ptr,
                                           input logic [3:0] win);
      logic [3:0] val;
      val = `AWR_NIBBLE_ZERO;
      // top nibble is wired to zero and holds no storage
      unique case (addr)
         `AWR_OFS_PTR_TOP: val = `AWR_TOP_NIBBLE;
         `AWR_OFS_PTR_HIGH: val = ptr[11:8];
         `AWR_OFS_PTR_MID: val = ptr[7:4];
         `AWR_OFS_PTR_LOW: val = ptr[3:0];
         `AWR_OFS_WINDOW: val = win;
         default: val = `AWR_NIBBLE_ZERO;
      endcase
      return val;
   endfunction

   logic [11:0] program_pointer; // the 12-bit pointer
   logic [11:0] next_program_pointer;
   logic [3:0] window_transfer_reg; // window nibble, no reset
   logic [3:0] next_window_transfer_reg;
   logic [11:0] stack_rdata; // entry at stack pointer
   logic do_push; // stack push strobe
   logic do_pop; // stack pop strobe
   awr_state_type state; // table read sequence
   awr_state_type next_state;
   logic [3:0] sys_rdata;
   logic [3:0] next_sys_rdata;
   logic rf_wr;
   logic next_rf_wr;
   logic [6:0] rf_addr;
   logic [6:0] next_rf_addr;
   logic [3:0] rf_wdata;
   logic [3:0] next_rf_wdata;
   logic rom_rd;
   logic next_rom_rd;
   logic [11:0] rom_addr;
   logic [11:0] next_rom_addr;
   logic dbf_load;
   logic next_dbf_load;
   logic [15:0] dbf_data;
   logic [15:0] next_dbf_data;
   logic pc_load;
   logic next_pc_load;
   logic call;
   logic next_call;
   logic [11:0] pc_target;
   logic [11:0] next_pc_target;

   // stack strobes straight from the op decode
   // a clearing pulse does not hold back a push or pop
   assign do_push = (op_i == AWR_OP_PUSH);
   assign do_pop = (op_i == AWR_OP_POP);

   // address stack and its pointer
   // entries survive every reset; the stack pointer clears on nrst_i only
   awr_stack u_stack (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .en_i(ce_i),
      .push_i(do_push),
      .pop_i(do_pop),
      .wdata_i(program_pointer),
      .rdata_o(stack_rdata),
      .sp_o(sp_o)
   );

   // next pointer value
   // clearing pulses win over every pointer op, so a pointer update in that cycle is lost
   // a data buffer load wins over a nibble write in the same cycle
   always_comb begin
      next_program_pointer = program_pointer;
      if (clock_stop_i || ce_reset_i) begin
         next_program_pointer = `AWR_PTR_RESET;
      end else if (op_i == AWR_OP_INC) begin
         // 12-bit add wraps 0FFF to 0000 on its own
         next_program_pointer = program_pointer + `AWR_PTR_ONE;
      end else if (op_i == AWR_OP_POP) begin
         next_program_pointer = stack_rdata;
      end else if (dbf_ptr_load_i) begin
         next_program_pointer = dbf_ptr_data_i;
      end else if (sys_i.wr) begin
         // nibble writes; the top nibble ignores writes
         unique case (sys_i.addr)
            `AWR_OFS_PTR_HIGH: next_program_pointer[11:8] = sys_i.wdata;
            `AWR_OFS_PTR_MID: next_program_pointer[7:4] = sys_i.wdata;
            `AWR_OFS_PTR_LOW: next_program_pointer[3:0] = sys_i.wdata;
            default: next_program_pointer = program_pointer;
         endcase
      end
   end

   // pointer register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         program_pointer <= `AWR_PTR_RESET;
      end else if (ce_i) begin
         program_pointer <= next_program_pointer;
      end
   end

   // next window value
   always_comb begin
      next_window_transfer_reg = window_transfer_reg;
      if (op_i == AWR_OP_FREAD) begin
         next_window_transfer_reg = rf_rdata_i;
      end else if (sys_i.wr && sys_i.addr == `AWR_OFS_WINDOW) begin
         next_window_transfer_reg = sys_i.wdata;
      end
   end

   // window register has no reset and ignores stop and ce resets
   // software must load the window before its first file write
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         window_transfer_reg <= next_window_transfer_reg;
      end
   end

   // next read nibble for system register reads
   always_comb begin
      next_sys_rdata = sys_rdata;
      if (sys_i.rd) begin
         // unmapped offsets answer zero
         next_sys_rdata = sys_read(sys_i.addr, program_pointer, window_transfer_reg);
      end
   end

   // read nibble register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sys_rdata <= `AWR_NIBBLE_ZERO;
      end else if (ce_i) begin
         sys_rdata <= next_sys_rdata;
      end
   end

   // table read sequence: request, then hand the word over
   // a second table read during the fetch is dropped, so the
   // sequencer leaves one idle cycle between two of them
   always_comb begin
      next_state = state;
      next_rom_rd = 1'b0;
      next_rom_addr = rom_addr;
      next_dbf_load = 1'b0;
      next_dbf_data = dbf_data;
      unique case (state)
         AWR_IDLE: begin
            if (op_i == AWR_OP_TREAD) begin
               next_rom_rd = 1'b1;
               next_rom_addr = program_pointer;
               next_state = AWR_FETCH;
            end
         end
         AWR_FETCH: begin
            // rom answers in the same cycle as the read strobe
            next_dbf_data = rom_data_i;
            next_dbf_load = 1'b1;
            next_state = AWR_IDLE;
         end
      endcase
   end

   // table read registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state <= AWR_IDLE;
         rom_rd <= 1'b0;
         rom_addr <= `AWR_PTR_RESET;
         dbf_load <= 1'b0;
         dbf_data <= 16'h0000;
      end else if (ce_i) begin
         state <= next_state;
         rom_rd <= next_rom_rd;
         rom_addr <= next_rom_addr;
         dbf_load <= next_dbf_load;
         dbf_data <= next_dbf_data;
      end
   end

   // indirect branch and call towards the program counter
   always_comb begin
      next_pc_load = 1'b0;
      next_call = 1'b0;
      next_pc_target = pc_target;
      if (op_i == AWR_OP_BR || op_i == AWR_OP_CALL) begin
         next_pc_load = 1'b1;
         next_call = (op_i == AWR_OP_CALL);
         // pointer taken as it stands, never index-modified
         next_pc_target = program_pointer;
      end
   end

   // branch registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pc_load <= 1'b0;
         call <= 1'b0;
         pc_target <= `AWR_PTR_RESET;
      end else if (ce_i) begin
         pc_load <= next_pc_load;
         call <= next_call;
         pc_target <= next_pc_target;
      end
   end

   // file write: window nibble to the named file location
   always_comb begin
      next_rf_wr = 1'b0;
      next_rf_addr = rf_addr;
      next_rf_wdata = rf_wdata;
      if (op_i == AWR_OP_FWRITE) begin
         next_rf_wr = 1'b1;
         next_rf_addr = rf_addr_i;
         next_rf_wdata = window_transfer_reg;
      end
   end

   // file write registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rf_wr <= 1'b0;
         rf_addr <= 7'h00;
         rf_wdata <= `AWR_NIBBLE_ZERO;
      end else if (ce_i) begin
         rf_wr <= next_rf_wr;
         rf_addr <= next_rf_addr;
         rf_wdata <= next_rf_wdata;
      end
   end

   // mirrors of the pointer and window for the data buffer side
   // window mirror shows zero only while nrst_i holds, then follows the undefined window
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         window_o <= `AWR_NIBBLE_ZERO;
         program_pointer_o <= `AWR_PTR_RESET;
      end else if (ce_i) begin
         window_o <= next_window_transfer_reg;
         program_pointer_o <= next_program_pointer;
      end
   end

   // outputs come straight from the registers above
   assign sys_rdata_o = sys_rdata;
   assign rf_wr_o = rf_wr;
   assign rf_addr_o = rf_addr;
   assign rf_wdata_o = rf_wdata;
   assign rom_rd_o = rom_rd;
   assign rom_addr_o = rom_addr;
   assign dbf_load_o = dbf_load;
   assign dbf_data_o = dbf_data;
   assign pc_load_o = pc_load;
   assign call_o = call;
   assign pc_target_o = pc_target;
endmodule

// file: bench/awr_far_model.sv
// program memory and register file model facing the core
`timescale 1ns/1ns
module awr_far_model (
   input wire logic clk_i,
   input wire logic [11:0] rom_addr_i,
   output logic [15:0] rom_data_o,
   input wire logic rf_wr_i,
   input wire logic [6:0] rf_waddr_i,
   input wire logic [3:0] rf_wdata_i,
   input wire logic [6:0] rf_raddr_i,
   output logic [3:0] rf_rdata_o
);
   logic [3:0] rf [128]; // nibble file contents
   // constant word is a fixed function of its location
   assign rom_data_o = {rom_addr_i[3:0], ~rom_addr_i};
   assign rf_rdata_o = rf[rf_raddr_i]; // file nibble at the named location
   initial for (int i = 0; i < 128; i++) rf[i] = i[3:0] ^ 4'h5;
   // file takes the window nibble on a write strobe
   always @(posedge clk_i) if (rf_wr_i) rf[rf_waddr_i] <= rf_wdata_i;
endmodule

// file: bench/awr_core_chk.sv
// assertions on the core ports
`timescale 1ns/1ns
module awr_core_chk
   import awr_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic clock_stop_i,
   input wire logic ce_reset_i,
   input wire awr_op_type op_i,
   input wire logic [6:0] rf_addr_i,
   input wire logic [3:0] rf_rdata_i,
   input wire awr_sys_req_type sys_i,
   input wire logic [15:0] rom_data_i,
   input wire logic dbf_ptr_load_i,
   input wire logic [11:0] dbf_ptr_data_i,
   input wire logic [3:0] sys_rdata_o,
   input wire logic [11:0] program_pointer_o,
   input wire logic [3:0] window_o,
   input wire logic rf_wr_o,
   input wire logic [6:0] rf_addr_o,
   input wire logic [3:0] rf_wdata_o,
   input wire logic rom_rd_o,
   input wire logic [11:0] rom_addr_o,
   input wire logic dbf_load_o,
   input wire logic [15:0] dbf_data_o,
   input wire logic pc_load_o,
   input wire logic call_o,
   input wire logic [11:0] pc_target_o,
   input wire logic [2:0] sp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic go; // an op taken with no clearing pulse
   assign go = ce_i && !clock_stop_i && !ce_reset_i;
   // fetch request at the old pointer
   sequence s_fetch;
      rom_rd_o && rom_addr_o == $past(program_pointer_o);
   endsequence
   // fetched word handed to the data buffer
   sequence s_deliver;
      dbf_load_o && dbf_data_o == $past(rom_data_i);
   endsequence
   chk_top_zero: assert property (ce_i && sys_i.rd && sys_i.addr == 7'h74 |=> sys_rdata_o == 4'h0)
      else $error("top nibble not zero");
   chk_ptr_clear: assert property (ce_i && (clock_stop_i || ce_reset_i) |=> program_pointer_o == 12'h000)
      else $error("pointer not cleared");
   chk_table_read: assert property (go && op_i == AWR_OP_TREAD && !rom_rd_o |=> s_fetch ##1 s_deliver)
      else $error("table read wrong");
   chk_push_sp: assert property (go && op_i == AWR_OP_PUSH |=> sp_o == $past(sp_o) - 3'h1)
      else $error("push stack pointer");
   chk_pop_sp: assert property (go && op_i == AWR_OP_POP |=> sp_o == $past(sp_o) + 3'h1)
      else $error("pop stack pointer");
   chk_branch_target: assert property (go && op_i == AWR_OP_BR |=>
      pc_load_o && !call_o && pc_target_o == $past(program_pointer_o))
      else $error("branch target");
   chk_call_target: assert property (go && op_i == AWR_OP_CALL |=>
      call_o && pc_target_o == $past(program_pointer_o))
      else $error("call target");
   chk_inc_wrap: assert property (go && op_i == AWR_OP_INC |=>
      program_pointer_o == $past(program_pointer_o) + 12'h001)
      else $error("increment wrong");
   chk_file_read: assert property (go && op_i == AWR_OP_FREAD |=> window_o == $past(rf_rdata_i))
      else $error("file read wrong");
   chk_file_write: assert property (go && op_i == AWR_OP_FWRITE |=> rf_wr_o &&
      rf_addr_o == $past(rf_addr_i) && rf_wdata_o == $past(window_o))
      else $error("file write wrong");
   chk_window_keep: assert property (ce_i && (clock_stop_i || ce_reset_i) &&
      op_i != AWR_OP_FREAD && !sys_i.wr |=> $stable(window_o))
      else $error("window lost");
   chk_ptr_load: assert property (go && op_i != AWR_OP_INC && op_i != AWR_OP_POP && dbf_ptr_load_i |=>
      program_pointer_o == $past(dbf_ptr_data_i))
      else $error("pointer load wrong");
   chk_window_write: assert property (ce_i && sys_i.wr && sys_i.addr == 7'h78 && op_i != AWR_OP_FREAD |=>
      window_o == $past(sys_i.wdata))
      else $error("window write wrong");
endmodule

// file: bench/testbench.sv
// self-checking bench for the address and window registers
`timescale 1ns/1ns
`define CHK(a, b) begin \
   total_checks++; \
   if ((a) !== (b)) begin \
      n_mismatch++; \
      $display("[ERR] %0t result mismatch, got %h expected %h", $time, a, b); \
   end \
end
module testbench;
   import awr_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, clock_stop_i = 1'b0, ce_reset_i = 1'b0, dbf_ptr_load_i = 1'b0;
   awr_op_type op_i = AWR_OP_NONE; // op under test
   awr_sys_req_type sys_i = '0; // register access
   logic [6:0] rf_addr_i = 7'h00, rf_addr_o;
   logic [3:0] rf_rdata_i, sys_rdata_o, window_o, rf_wdata_o, v;
   logic [15:0] rom_data_i, dbf_data_o;
   logic [11:0] dbf_ptr_data_i = 12'h000, program_pointer_o, rom_addr_o, pc_target_o, a, b;
   logic rf_wr_o, rom_rd_o, dbf_load_o, pc_load_o, call_o, rd_d = 1'b0;
   logic [2:0] sp_o;
   logic [18:0] exp_q [$]; // notes: kind and value
   logic [3:0] fm [128]; // shadow of the file
   int n_mismatch = 0, total_checks = 0, seed = 76;
   awr_core uut (.*);
   awr_far_model far (.clk_i(clk_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i), .rf_wr_i(rf_wr_o),
      .rf_waddr_i(rf_addr_o), .rf_wdata_i(rf_wdata_o), .rf_raddr_i(rf_addr_i), .rf_rdata_o(rf_rdata_i));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic op(input awr_op_type o);
      @(negedge clk_i) op_i = o;
      @(negedge clk_i) op_i = AWR_OP_NONE;
   endtask
   task automatic wr(input logic [6:0] ad, input logic [3:0] d);
      @(negedge clk_i) sys_i = '{1'b1, 1'b0, ad, d};
      @(negedge clk_i) sys_i = '0;
   endtask
   // read note then strobe
   task automatic rd(input logic [6:0] ad, input logic [3:0] e);
      exp_q.push_back({3'h5, 12'h000, e});
      @(negedge clk_i) sys_i = '{1'b0, 1'b1, ad, 4'h0};
      @(negedge clk_i) sys_i = '0;
   endtask
   // pointer seen through a branch
   task automatic ptr(input logic [11:0] e);
      exp_q.push_back({3'h1, 4'h0, e});
      op(AWR_OP_BR);
   endtask
   task automatic setp(input logic [11:0] p);
      wr(7'h74, 4'hf);
      for (int i = 0; i < 3; i++) wr(7'h75 + i[6:0], p[11 - 4 * i -: 4]);
   endtask
   task automatic rdp(input logic [11:0] p);
      rd(7'h74, 4'h0);
      for (int i = 0; i < 3; i++) rd(7'h75 + i[6:0], p[11 - 4 * i -: 4]);
   endtask
   task automatic dload(input logic [11:0] p);
      @(negedge clk_i);
      dbf_ptr_load_i = 1'b1;
      dbf_ptr_data_i = p;
      @(negedge clk_i);
      dbf_ptr_load_i = 1'b0;
   endtask
   // one clearing pulse, clock stop or chip-enable reset
   task automatic clr(input logic st);
      @(negedge clk_i);
      clock_stop_i = st;
      ce_reset_i = !st;
      @(negedge clk_i);
      clock_stop_i = 1'b0;
      ce_reset_i = 1'b0;
   endtask
   task automatic print_verdict;
      if (exp_q.size() != 0)
         n_mismatch++;
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watcher pairs each result with the oldest note
   always @(posedge clk_i) begin
      logic [18:0] got;
      logic [18:0] e;
      rd_d <= nrst_i && ce_i && sys_i.rd;
      got = call_o ? {3'h2, 4'h0, pc_target_o} : pc_load_o ? {3'h1, 4'h0, pc_target_o} : rf_wr_o ?
         {3'h3, 5'h00, rf_addr_o, rf_wdata_o} : dbf_load_o ? {3'h4, dbf_data_o} : {3'h5, 12'h000, sys_rdata_o};
      if (nrst_i && (pc_load_o || call_o || rf_wr_o || dbf_load_o || rd_d)) begin
         e = exp_q.size() ? exp_q.pop_front() : 19'h7_ffff;
         `CHK(got, e)
      end
   end
   // main sequence
   initial begin
      for (int i = 0; i < 128; i++) fm[i] = i[3:0] ^ 4'h5;
      repeat (12) @(negedge clk_i);
      nrst_i = 1'b1;
      rdp(12'h000);
      repeat (4) begin
         a = 12'($random(seed));
         b = 12'($random(seed));
         v = 4'($random(seed));
         setp(a);
         rdp(a);
         ptr(a);
         exp_q.push_back({3'h2, 4'h0, a});
         op(AWR_OP_CALL);
         exp_q.push_back({3'h4, a[3:0], ~a});
         op(AWR_OP_TREAD);
         op(AWR_OP_PUSH);
         dload(b);
         rdp(b);
         op(AWR_OP_PUSH);
         op(AWR_OP_INC);
         op(AWR_OP_POP);
         ptr(b);
         op(AWR_OP_POP);
         ptr(a);
         op(AWR_OP_INC);
         ptr(a + 12'h001);
         rf_addr_i = b[6:0];
         op(AWR_OP_FREAD);
         rd(7'h78, fm[b[6:0]]);
         wr(7'h78, v);
         rf_addr_i = a[6:0];
         exp_q.push_back({3'h3, 5'h00, a[6:0], v});
         op(AWR_OP_FWRITE);
         fm[a[6:0]] = v;
         clr(a[0]);
         rd(7'h78, v);
         ptr(12'h000);
      end
      dload(12'hfff);
      op(AWR_OP_INC);
      ptr(12'h000);
      @(negedge clk_i) ce_i = 1'b0;
      op(AWR_OP_INC);
      ce_i = 1'b1;
      ptr(12'h000);
      dload(b);
      nrst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      nrst_i = 1'b1;
      rdp(12'h000);
      repeat (4) @(negedge clk_i);
      print_verdict();
   end
   // watchdog cuts a hang short
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule
bind awr_core awr_core_chk chk (.*);
